// *** hdl/pic_pkg.sv ***
package pic_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_A = 8'h05;
    localparam logic [7:0] ADDR_PORT_B = 8'h06;
    localparam logic [7:0] ADDR_OPEN_DRAIN = 8'h0C;
    localparam logic [7:0] ADDR_PULL_HIGH = 8'h0D;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0E;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0F;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_TMR = 0;
    localparam int BIT_PBC = 1;
    localparam int BIT_EXT = 2;
    localparam int BIT_GLOBAL_EN = 7;
    localparam int OPT_PS_LO = 0;
    localparam int OPT_PS_OWNER = 3;
    localparam int OPT_SRC_EDGE = 4;
    localparam int OPT_CLK_SRC = 5;
    localparam int OPT_EDGE = 6;
    localparam int PIN_INPUT_ONLY = 3;
    localparam int PIN_COUNT_IN = 2;
    localparam int PIN_EXT_IRQ = 0;
    // ------------------------------------------------------------
    // Reset values and fixed read bits
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OPTION = 8'hBF;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
    localparam logic [7:0] RST_PULL_HIGH = 8'hFF;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] MASK_ONES = 8'h78;
    localparam logic [7:0] MASK_STORED = 8'h87;
    localparam logic [7:0] FLAG_BITS = 8'h07;
    localparam logic [9:0] IRQ_VECTOR = 10'h008;
    // ------------------------------------------------------------
    // Core side request bundle
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pic_req_t;
endpackage : pic_pkg

// *** hdl/pic_port_irq.sv ***
`timescale 1ns/1ps
// Functional notes
// RULE1 - Open-drain bit set enables pin open-drain
// RULE2 - Bit 3 of both controls: plain storage
// RULE3 - Pull-high bits active low per pin
// RULE4 - Outputs never get weak pulls
// RULE5 - Open-drain matters only in output mode
// RULE6 - Mask bits 0,1,2,7; bits 6-3 read one
// RULE7 - Wake branches to vector only with global enable
// RULE8 - Taken interrupt clears global enable in hardware
// RULE9 - Return from interrupt sets global enable
// RULE10 - Flags bits 0-2, set by hardware, cleared by software
// RULE11 - External edge chosen by edge select bit
// RULE12 - Option load copies accumulator, bit7 unused
// RULE13 - Option resets ones except edge select
// RULE14 - Ratio code doubles; timer from 1:2, watchdog 1:1
// RULE15 - Assign bit one gives prescaler to watchdog
// RULE16 - Source edge one counts falling edges
// RULE17 - External count source forces pin 2 input
// RULE18 - Direction load copies accumulator; 1 means input
// RULE19 - Directions reset to all inputs
// RULE20 - Port A four pins, port B eight, pin 3 input only
// RULE21 - Interrupt pin select masks pin 0 change
// RULE22 - Alternate-function pins read as zero
// RULE23 - Port read shows pins, write sets latch
// RULE24 - Flags set regardless of mask; read ANDed with mask
// RULE25 - Disabled or output pins excluded from change detect
// RULE26 - Change compares against value latched at last access
module pic_port_irq #(
    parameter int PA_W = 4, // Port A pin count
    parameter int PB_W = 8 // Port B pin count
) (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_i, // Async reset, active high
    input wire pic_pkg::pic_req_t req_i, // Register access from core
    output logic [7:0] rdata_o, // Registered read data
    input wire logic [7:0] acc_i, // Accumulator value
    input wire logic opt_load_i, // Option-load instruction
    input wire logic dir_load_i, // Direction-load instruction
    input wire logic dir_sel_b_i, // Direction target: 1 = port B
    input wire logic irq_return_i, // Return-from-interrupt instruction
    input wire logic sleep_i, // Core is asleep
    input wire logic timer_ovf_i, // Timer0 overflow pulse
    input wire logic [7:0] change_wake_enable_i, // Per-pin change enables
    input wire logic ext_interrupt_pin_select_i, // Pin 0 is interrupt input
    input wire logic [PA_W-1:0] alt_fn_a_i, // Alternate-function pins A
    input wire logic [PB_W-1:0] alt_fn_b_i, // Alternate-function pins B
    input wire logic [PA_W-1:0] pa_in_i, // Port A pin levels
    input wire logic [PB_W-1:0] pb_in_i, // Port B pin levels
    output logic [PA_W-1:0] pa_out_o, // Port A output value
    output logic [PA_W-1:0] pa_oe_o, // Port A output enable
    output logic [PB_W-1:0] pb_out_o, // Port B output value
    output logic [PB_W-1:0] pb_oe_o, // Port B output enable
    output logic [PB_W-1:0] pb_pull_high_o, // Port B weak pull-high on
    output logic [PA_W-1:0] pa_pd_allow_o, // Port A pull-down permitted
    output logic [PB_W-1:0] pb_pd_allow_o, // Port B pull-down permitted
    output logic irq_take_o, // Branch to vector pulse
    output logic [9:0] irq_vector_o, // Vector address
    output logic wake_o, // Wake-up request, held while asleep with an enabled flag pending
    output logic [7:0] option_o, // Option register contents
    output logic [8:0] tmr_ratio_o, // Timer0 divide ratio
    output logic [7:0] wdt_ratio_o, // Watchdog divide ratio
    output logic prescaler_to_wdt_o, // Prescaler assigned to watchdog
    output logic count_falling_o, // External count on falling edge
    output logic count_external_o // Timer0 counts external pin
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [PA_W-1:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_lvl_q;
    logic [PB_W-1:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_lvl_q;
    logic [7:0] lat_a_q, lat_b_q, dir_a_q, dir_b_q;
    logic [7:0] open_drain_select_q, pull_high_select_q;
    logic [7:0] interrupt_mask_q, flags_q, option_q;
    logic [PB_W-1:0] pb_snap_q;
    logic ext_prev_q;
    logic [PB_W-1:0] pb_is_in, pb_change_en, pb_out_d, pb_oe_d;
    logic [PA_W-1:0] pa_oe_d;
    logic wr_mask, wr_flags, pb_access;
    logic ev_tmr, ev_pbc, ev_ext, ext_now;
    logic [7:0] ev_vec, pend;
    logic take, wake_d;
    logic [7:0] rd_d;

    assign wr_mask = req_i.wr && (req_i.addr == pic_pkg::ADDR_IRQ_MASK);
    assign wr_flags = req_i.wr && (req_i.addr == pic_pkg::ADDR_IRQ_FLAGS);
    assign pb_access = (req_i.wr || req_i.rd) && (req_i.addr == pic_pkg::ADDR_PORT_B);

    // ------------------------------------------------------------
    // Pin synchronisers: three stages, accept when last two agree
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pa_s1_q <= '0;
            pa_s2_q <= '0;
            pa_s3_q <= '0;
            pb_s1_q <= '0;
            pb_s2_q <= '0;
            pb_s3_q <= '0;
        end else begin
            pa_s1_q <= pa_in_i;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            pb_s1_q <= pb_in_i;
            pb_s2_q <= pb_s1_q;
            pb_s3_q <= pb_s2_q;
        end
    end

    // Filtered levels update only where stages agree
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pa_lvl_q <= '0;
            pb_lvl_q <= '0;
        end else begin
            pa_lvl_q <= (pa_s2_q & pa_s3_q) | (pa_lvl_q & (pa_s2_q ^ pa_s3_q));
            pb_lvl_q <= (pb_s2_q & pb_s3_q) | (pb_lvl_q & (pb_s2_q ^ pb_s3_q));
        end
    end

    // ------------------------------------------------------------
    // Port latches and pin control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lat_a_q <= '0;
            lat_b_q <= '0;
            open_drain_select_q <= pic_pkg::RST_OPEN_DRAIN;
            pull_high_select_q <= pic_pkg::RST_PULL_HIGH;
        end else if (req_i.wr) begin
            unique case (req_i.addr)
                pic_pkg::ADDR_PORT_A: lat_a_q <= req_i.wdata; // RULE23
                pic_pkg::ADDR_PORT_B: lat_b_q <= req_i.wdata; // RULE23
                pic_pkg::ADDR_OPEN_DRAIN: open_drain_select_q <= req_i.wdata; // RULE1 RULE2
                pic_pkg::ADDR_PULL_HIGH: pull_high_select_q <= req_i.wdata; // RULE3 RULE2
                default: begin
                end
            endcase
        end
    end

    // Direction registers loaded by direction-load instruction
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dir_a_q <= pic_pkg::RST_DIR; // RULE19
            dir_b_q <= pic_pkg::RST_DIR; // RULE19
        end else if (dir_load_i) begin
            if (dir_sel_b_i) begin
                dir_b_q <= acc_i; // RULE18
            end else begin
                dir_a_q <= acc_i; // RULE18
            end
        end
    end

    // Option register loaded by option-load instruction
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            option_q <= pic_pkg::RST_OPTION; // RULE13
        end else if (opt_load_i) begin
            option_q <= acc_i; // RULE12
        end
    end

    // ------------------------------------------------------------
    // Pin driver decisions, one per port B pin
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PB_W; gi++) begin : g_pb
            if (gi == pic_pkg::PIN_INPUT_ONLY) begin : g_in_only
                assign pb_is_in[gi] = 1'b1; // RULE20
            end else if (gi == pic_pkg::PIN_COUNT_IN) begin : g_cnt
                assign pb_is_in[gi] = dir_b_q[gi] || option_q[pic_pkg::OPT_CLK_SRC]; // RULE17
            end else begin : g_norm
                assign pb_is_in[gi] = dir_b_q[gi]; // RULE18
            end
            // Open-drain: drive only lows; input mode always floats
            assign pb_oe_d[gi] = !pb_is_in[gi] &&
                (!open_drain_select_q[gi] || !lat_b_q[gi]); // RULE1 RULE5
            assign pb_out_d[gi] = lat_b_q[gi];
            assign pb_change_en[gi] = change_wake_enable_i[gi] && pb_is_in[gi] &&
                !(gi == pic_pkg::PIN_EXT_IRQ && ext_interrupt_pin_select_i); // RULE25 RULE21
        end
    endgenerate
    assign pa_oe_d = ~dir_a_q[PA_W-1:0];

    // Registered pin outputs, weak pulls dropped in output mode
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pa_out_o <= '0;
            pa_oe_o <= '0;
            pb_out_o <= '0;
            pb_oe_o <= '0;
            pb_pull_high_o <= '0;
            pa_pd_allow_o <= '0;
            pb_pd_allow_o <= '0;
        end else begin
            pa_out_o <= lat_a_q[PA_W-1:0];
            pa_oe_o <= pa_oe_d;
            pb_out_o <= pb_out_d;
            pb_oe_o <= pb_oe_d;
            pb_pull_high_o <= ~pull_high_select_q[PB_W-1:0] & pb_is_in &
                ~(8'(1) << pic_pkg::PIN_INPUT_ONLY); // RULE3 RULE4 RULE2
            pa_pd_allow_o <= ~pa_oe_d; // RULE4
            pb_pd_allow_o <= pb_is_in; // RULE4
        end
    end

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    assign ext_now = pb_lvl_q[pic_pkg::PIN_EXT_IRQ];
    assign ev_ext = ext_interrupt_pin_select_i && (option_q[pic_pkg::OPT_EDGE] ?
        (ext_now && !ext_prev_q) : (!ext_now && ext_prev_q)); // RULE11
    assign ev_pbc = |((pb_lvl_q ^ pb_snap_q) & pb_change_en); // RULE26
    assign ev_tmr = timer_ovf_i;
    assign ev_vec = {5'h00, ev_ext, ev_pbc, ev_tmr};

    // Edge history and change snapshot taken at port B access
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ext_prev_q <= 1'b0;
            pb_snap_q <= '0;
        end else begin
            ext_prev_q <= ext_now;
            if (pb_access) begin
                pb_snap_q <= pb_lvl_q; // RULE26
            end
        end
    end

    // Sticky flags: set beats software clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flags_q <= '0;
        end else if (wr_flags) begin
            flags_q <= (req_i.wdata & flags_q & pic_pkg::FLAG_BITS) | ev_vec; // RULE10
        end else begin
            flags_q <= flags_q | ev_vec; // RULE24 RULE10
        end
    end

    // Pending enabled interrupts and branch decision
    assign pend = flags_q & interrupt_mask_q & pic_pkg::FLAG_BITS;
    assign take = interrupt_mask_q[pic_pkg::BIT_GLOBAL_EN] && (|pend); // RULE8 RULE7
    assign wake_d = sleep_i && (|pend);

    // Mask register with hardware global-enable control
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            interrupt_mask_q <= pic_pkg::RST_MASK;
        end else begin
            if (wr_mask) begin
                interrupt_mask_q <= req_i.wdata & pic_pkg::MASK_STORED; // RULE6
            end
            if (irq_return_i) begin
                interrupt_mask_q[pic_pkg::BIT_GLOBAL_EN] <= 1'b1; // RULE9
            end
            if (take) begin
                interrupt_mask_q[pic_pkg::BIT_GLOBAL_EN] <= 1'b0; // RULE8
            end
        end
    end

    // Branch pulse and wake level
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_take_o <= 1'b0;
            wake_o <= 1'b0;
            irq_vector_o <= pic_pkg::IRQ_VECTOR;
        end else begin
            irq_take_o <= take; // RULE7
            wake_o <= wake_d; // RULE7
            irq_vector_o <= pic_pkg::IRQ_VECTOR;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_d = 8'h00;
        unique case (req_i.addr)
            pic_pkg::ADDR_PORT_A: rd_d = {lat_a_q[7:PA_W],
                pa_lvl_q & ~alt_fn_a_i}; // RULE23 RULE22
            pic_pkg::ADDR_PORT_B: rd_d = pb_lvl_q & ~alt_fn_b_i; // RULE23 RULE22
            pic_pkg::ADDR_OPEN_DRAIN: rd_d = open_drain_select_q;
            pic_pkg::ADDR_PULL_HIGH: rd_d = pull_high_select_q;
            pic_pkg::ADDR_IRQ_MASK: rd_d = interrupt_mask_q | pic_pkg::MASK_ONES; // RULE6
            pic_pkg::ADDR_IRQ_FLAGS: rd_d = flags_q & interrupt_mask_q &
                pic_pkg::FLAG_BITS; // RULE24 RULE10
            default: rd_d = 8'h00;
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (req_i.rd) begin
            rdata_o <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // Option decode for timer and prescaler
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            option_o <= pic_pkg::RST_OPTION;
            tmr_ratio_o <= 9'h100;
            wdt_ratio_o <= 8'h80;
            prescaler_to_wdt_o <= 1'b1;
            count_falling_o <= 1'b1;
            count_external_o <= 1'b1;
        end else begin
            option_o <= option_q;
            tmr_ratio_o <= 9'h002 << option_q[pic_pkg::OPT_PS_LO +: 3]; // RULE14
            wdt_ratio_o <= 8'h01 << option_q[pic_pkg::OPT_PS_LO +: 3]; // RULE14
            prescaler_to_wdt_o <= option_q[pic_pkg::OPT_PS_OWNER]; // RULE15
            count_falling_o <= option_q[pic_pkg::OPT_SRC_EDGE]; // RULE16
            count_external_o <= option_q[pic_pkg::OPT_CLK_SRC]; // RULE17
        end
    end

endmodule // pic_port_irq

// *** tb/pic_pins.sv ***
`timescale 1ns/1ps
// Pad model: driver wins, then outside source, then weak pull, else drift
module pic_pins #(
    parameter int W = 8 // Pad count
) (
    input wire logic clk_sys_i, // System clock
    input wire logic [W-1:0] out_i, // Pad output value
    input wire logic [W-1:0] oe_i, // Pad drive enable
    input wire logic [W-1:0] pull_i, // Weak pull-high on
    input wire logic [W-1:0] ext_en_i, // Outside source drives
    input wire logic [W-1:0] ext_i, // Outside source value
    output logic [W-1:0] lvl_o // Resolved pad level
);
    logic [W-1:0] last_q;
    // Floating pads flip every cycle
    always_ff @(posedge clk_sys_i) begin
        last_q <= lvl_o;
    end
    // Level per pad
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_i[i]) begin
                lvl_o[i] = out_i[i];
            end else if (ext_en_i[i]) begin
                lvl_o[i] = ext_i[i];
            end else if (pull_i[i]) begin
                lvl_o[i] = 1'b1;
            end else begin
                lvl_o[i] = ~last_q[i];
            end
        end
    end
endmodule // pic_pins

// *** tb/pic_port_irq_chk.sv ***
`timescale 1ns/1ps
module pic_chk #(
    parameter int PA_W = 4, // Port A pin count
    parameter int PB_W = 8 // Port B pin count
) (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_i, // Async reset
    input wire pic_pkg::pic_req_t req_i, // Register access
    input wire logic [7:0] acc_i, // Accumulator
    input wire logic opt_load_i, // Option load
    input wire logic [7:0] rdata_o, // Read data
    input wire logic [PB_W-1:0] pb_oe_o, // Port B drive enable
    input wire logic [PB_W-1:0] pb_pull_high_o, // Port B pull-high
    input wire logic [PB_W-1:0] pb_pd_allow_o, // Port B pull-down allowed
    input wire logic irq_take_o, // Vector branch
    input wire logic [9:0] irq_vector_o, // Vector address
    input wire logic [7:0] option_o, // Option contents
    input wire logic [8:0] tmr_ratio_o, // Timer ratio
    input wire logic [7:0] wdt_ratio_o, // Watchdog ratio
    input wire logic prescaler_to_wdt_o, // Prescaler owner
    input wire logic count_falling_o, // Count edge
    input wire logic count_external_o // Count source
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Pin and pull checks
    property p_pin3;
        pb_oe_o[3] == 1'b0;
    endproperty
    a_pin3: assert property (p_pin3) else $error("input-only pin driven");
    property p_pull;
        (pb_pull_high_o & pb_oe_o) == '0 && (pb_pd_allow_o & pb_oe_o) == '0;
    endproperty
    a_pull: assert property (p_pull) else $error("weak pull on output pin");
    // Option decoding checks
    property p_ratio;
        $stable(option_o) |-> tmr_ratio_o == (9'h002 << option_o[2:0])
            && wdt_ratio_o == (8'h01 << option_o[2:0]);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio mismatch");
    property p_owner;
        $stable(option_o) |-> prescaler_to_wdt_o == option_o[3] && count_falling_o == option_o[4];
    endproperty
    a_owner: assert property (p_owner) else $error("owner or edge mismatch");
    property p_count;
        $stable(option_o) [*2] |-> count_external_o == option_o[5]
            && !(count_external_o && pb_oe_o[2]);
    endproperty
    a_count: assert property (p_count) else $error("count source mismatch");
    property p_load;
        opt_load_i |-> ##2 option_o[6:0] == $past(acc_i[6:0], 2);
    endproperty
    a_load: assert property (p_load) else $error("option load lost");
    // Read-back and interrupt checks
    property p_mask_rd;
        req_i.rd && req_i.addr == 8'h0E |=> rdata_o[6:3] == 4'hF;
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask filler bits");
    property p_flag_rd;
        req_i.rd && req_i.addr == 8'h0F |=> rdata_o[7:3] == 5'h00;
    endproperty
    a_flag_rd: assert property (p_flag_rd) else $error("flag filler bits");
    property p_take;
        irq_take_o |=> !irq_take_o;
    endproperty
    a_take: assert property (p_take) else $error("branch repeated");
    property p_vec;
        irq_vector_o == 10'h008;
    endproperty
    a_vec: assert property (p_vec) else $error("vector address");
endmodule // pic_chk

bind pic_port_irq pic_chk #(.PA_W(PA_W), .PB_W(PB_W)) u_chk (.clk_sys_i, .rst_i, .req_i,
    .acc_i, .opt_load_i, .rdata_o, .pb_oe_o, .pb_pull_high_o, .pb_pd_allow_o, .irq_take_o,
    .irq_vector_o, .option_o, .tmr_ratio_o, .wdt_ratio_o, .prescaler_to_wdt_o,
    .count_falling_o, .count_external_o);

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic clk_sys_i, rst_i, opt_load, dir_load, dir_b, ret_irq, sleep, tovf, ext_sel;
    pic_pkg::pic_req_t req;
    logic [7:0] acc, cwe, alt_b, rdata, option, wdt_ratio, pb_ext, v;
    logic [3:0] pa_out, pa_oe, pa_lvl, pa_pd, alt_a, pa_ext;
    logic [7:0] pb_out, pb_oe, pb_ph, pb_lvl, pb_pd;
    logic [9:0] vec;
    logic [8:0] tmr_ratio;
    logic take, wake, to_wdt, fall, ext_cnt;
    int err_count = 0;
    int checks_done = 0;
    int takes = 0;
    int wakes = 0;
    pic_port_irq uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
        .acc_i(acc), .opt_load_i(opt_load), .dir_load_i(dir_load), .dir_sel_b_i(dir_b),
        .irq_return_i(ret_irq), .sleep_i(sleep), .timer_ovf_i(tovf), .change_wake_enable_i(cwe),
        .ext_interrupt_pin_select_i(ext_sel), .alt_fn_a_i(alt_a), .alt_fn_b_i(alt_b),
        .pa_in_i(pa_lvl), .pb_in_i(pb_lvl), .pa_out_o(pa_out), .pa_oe_o(pa_oe),
        .pb_out_o(pb_out), .pb_oe_o(pb_oe), .pb_pull_high_o(pb_ph), .pa_pd_allow_o(pa_pd),
        .pb_pd_allow_o(pb_pd), .irq_take_o(take), .irq_vector_o(vec), .wake_o(wake),
        .option_o(option), .tmr_ratio_o(tmr_ratio), .wdt_ratio_o(wdt_ratio),
        .prescaler_to_wdt_o(to_wdt), .count_falling_o(fall), .count_external_o(ext_cnt));
    pic_pins #(.W(4)) pins_a (.clk_sys_i(clk_sys_i), .out_i(pa_out), .oe_i(pa_oe),
        .pull_i(4'h0), .ext_en_i(~pa_oe), .ext_i(pa_ext), .lvl_o(pa_lvl));
    pic_pins #(.W(8)) pins_b (.clk_sys_i(clk_sys_i), .out_i(pb_out), .oe_i(pb_oe),
        .pull_i(pb_ph), .ext_en_i(8'hFF), .ext_i(pb_ext), .lvl_o(pb_lvl));
    // Clock and pulse counters
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (take === 1'b1) takes <= takes + 1;
        if (wake === 1'b1) wakes <= wakes + 1;
    end
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 req = '{rd: !w, wr: w, addr: a, wdata: d};
        settle(1);
        req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, 12'(exp), 12'(rdata));
    endtask
    // Kinds: 0 option, 1 dir A, 2 dir B, 3 return, 4 timer overflow
    task automatic instr(input int k, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 acc = d;
        opt_load = (k == 0);
        dir_load = (k == 1 || k == 2);
        dir_b = (k == 2);
        ret_irq = (k == 3);
        tovf = (k == 4);
        settle(1);
        {opt_load, dir_load, ret_irq, tovf} = '0;
        settle(3);
    endtask
    task automatic pins(input logic [7:0] d);
        pb_ext = d;
        settle(6);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {req, acc, opt_load, dir_load, dir_b, ret_irq, sleep, tovf, ext_sel, cwe, alt_b} = '0;
        pb_ext = 8'h00;
        {pa_ext, alt_a} = 8'h90;
        rst_i = 1'b1;
        settle(10);
        rst_i = 1'b0;
        chk("option", 12'h0BF, 12'(option));
        chk("dirs", 12'h000, 12'({pa_oe, pb_oe}));
        rd(8'h0E, 8'h78, "mask");
        rd(8'h0F, 8'h00, "flags");
        $display("test reset done");
        bus(1'b1, 8'h0C, 8'h08);
        rd(8'h0C, 8'h08, "odrain bit3");
        bus(1'b1, 8'h0D, 8'h08);
        rd(8'h0D, 8'h08, "pull bit3");
        bus(1'b1, 8'h0E, 8'h87);
        rd(8'h0E, 8'hFF, "mask all");
        bus(1'b1, 8'h0E, 8'h00);
        bus(1'b1, 8'h20, 8'h5A);
        rd(8'h20, 8'h00, "unmapped");
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            v = {1'b0, i[3], i[3], ~i[3], i[3], i[2:0]};
            instr(0, v);
            chk("option", 12'(v[6:0]), 12'(option[6:0]));
            chk("tmr ratio", 12'h002 << i[2:0], 12'(tmr_ratio));
            chk("wdt ratio", 12'h001 << i[2:0], 12'(wdt_ratio));
            chk("owner", 12'(v[5:3]), 12'({ext_cnt, fall, to_wdt}));
        end
        $display("test option done");
        instr(0, 8'h40);
        instr(1, 8'h00);
        bus(1'b1, 8'h05, 8'h0A);
        settle(2);
        chk("port a", 12'h0FA, 12'({pa_pd, pa_oe, pa_out}));
        bus(1'b1, 8'h0D, 8'h00);
        bus(1'b1, 8'h0C, 8'h00);
        bus(1'b1, 8'h06, 8'hA5);
        instr(2, 8'h00);
        chk("b oe", 12'h0F7, 12'(pb_oe));
        chk("b out", 12'h0A5, 12'(pb_out & pb_oe));
        chk("b pull", 12'h000, 12'(pb_ph));
        settle(2);
        rd(8'h06, 8'hA5, "b pins");
        alt_b = 8'h20;
        settle(2);
        rd(8'h06, 8'h85, "b alt");
        alt_a = 4'h2;
        rd(8'h05, 8'h08, "a alt");
        {alt_a, alt_b} = '0;
        bus(1'b1, 8'h0C, 8'hFF);
        settle(2);
        chk("b od oe", 12'h052, 12'(pb_oe));
        bus(1'b1, 8'h0C, 8'h00);
        instr(0, 8'h60);
        chk("b count oe", 12'h0F3, 12'(pb_oe));
        instr(0, 8'h40);
        bus(1'b1, 8'h0C, 8'hFF);
        instr(2, 8'hFF);
        chk("b in oe", 12'h000, 12'(pb_oe));
        chk("b pull on", 12'h0F7, 12'(pb_ph));
        bus(1'b1, 8'h0D, 8'h0F);
        settle(2);
        chk("b pull part", 12'h0F0, 12'(pb_ph));
        $display("test pins done");
        pins(8'h00);
        bus(1'b1, 8'h0E, 8'h81);
        instr(4, 8'h00);
        settle(2);
        chk("taken", 12'h001, 12'(takes));
        rd(8'h0E, 8'h79, "mask gie off");
        rd(8'h0F, 8'h01, "timer flag");
        bus(1'b1, 8'h0F, 8'h00);
        rd(8'h0F, 8'h00, "flag clear");
        instr(3, 8'h00);
        rd(8'h0E, 8'hF9, "mask gie on");
        bus(1'b1, 8'h0E, 8'h00);
        instr(4, 8'h00);
        rd(8'h0F, 8'h00, "masked flag");
        bus(1'b1, 8'h0E, 8'h01);
        rd(8'h0F, 8'h01, "unmasked flag");
        bus(1'b1, 8'h0F, 8'h00);
        $display("test irq done");
        ext_sel = 1'b1;
        cwe = 8'hFF;
        bus(1'b1, 8'h0E, 8'h06);
        rd(8'h06, 8'h00, "b snap");
        bus(1'b1, 8'h0F, 8'h00);
        pins(8'h01);
        rd(8'h0F, 8'h04, "ext rise");
        bus(1'b1, 8'h0F, 8'h00);
        instr(0, 8'h00);
        pins(8'h00);
        rd(8'h0F, 8'h04, "ext fall");
        bus(1'b1, 8'h0F, 8'h00);
        ext_sel = 1'b0;
        cwe = 8'hDF;
        rd(8'h06, 8'h00, "b snap");
        pins(8'h20);
        rd(8'h0F, 8'h00, "change off pin");
        bus(1'b1, 8'h0E, 8'h02);
        cwe = 8'hFF;
        sleep = 1'b1;
        settle(6);
        chk("wake", 12'h001, 12'(wakes != 0));
        chk("no branch", 12'h001, 12'(takes));
        rd(8'h0F, 8'h02, "change flag");
        bus(1'b1, 8'h0E, 8'h82);
        settle(4);
        chk("branch", 12'h002, 12'(takes));
        sleep = 1'b0;
        $display("test change done");
        wrap_up();
    end
endmodule // testbench
